// ---- hw/isl_pkg.sv ----
package isl_pkg;

  // frame geometry
  localparam int unsigned FRAME_BITS = 8;
  localparam int unsigned CNT_W = 3;
  // consecutive rejected link transfers before all stages go off
  localparam logic [2:0] FAIL_LIMIT = 3'h4;
  // output buffer value after reset and after disable
  localparam logic [7:0] OUT_RESET = 8'h00;
  // thermal duty pattern: on cycles and off cycles of the restart pwm
  localparam logic [7:0] THERM_ON_CYC = 8'h10;
  localparam logic [7:0] THERM_OFF_CYC = 8'hf0;
  // repetitive current limit switching: on cycles and off cycles of the limit pwm
  localparam logic [3:0] ILIM_ON_CYC = 4'h2;
  localparam logic [3:0] ILIM_OFF_CYC = 4'h6;
  // two-entry buffer depth
  localparam int unsigned BUF_DEPTH = 2;

  // serial pins after synchronisation
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
  } isl_spi_t;

  // a frame handed to the output stage, with its validity verdict
  typedef struct packed {
    logic ok;
    logic [7:0] data;
  } isl_frame_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEL
  } isl_state_t;

endpackage : isl_pkg

// ---- hw/isl_buf2.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer between the serial front end and the output stage
module isl_buf2 (
  input wire logic core_clk_i, // core clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic in_valid_i, // frame offered
  output logic in_ready_o, // room for a frame
  input wire isl_pkg::isl_frame_t in_data_i, // frame in
  output logic out_valid_o, // frame waiting
  input wire logic out_ready_i, // stage takes frame
  output isl_pkg::isl_frame_t out_data_o // oldest frame
);
  isl_pkg::isl_frame_t mem_ff [isl_pkg::BUF_DEPTH];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] cnt_ff;
  logic do_wr;
  logic do_rd;

  assign in_ready_o = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o = mem_ff[rd_ptr_ff];
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = out_valid_o && out_ready_i;

  // storage has no reset; count guards every read
  always_ff @(posedge core_clk_i) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (do_rd) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end

  // a full buffer never advertises room
  property p_full_blocks;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      cnt_ff == 2'h2 |-> !in_ready_o;
  endproperty
  a_full_blocks: assert property (p_full_blocks)
    else $error("buffer full but ready");

  property p_cnt_range;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (cnt_ff <= 2'h2);
  endproperty
  a_cnt_range: assert property (p_cnt_range)
    else $error("buffer count out of range");

  // a finished frame must always find room, else its verdict is lost
  property p_no_drop;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      in_valid_i |-> in_ready_o;
  endproperty
  a_no_drop: assert property (p_no_drop)
    else $error("frame offered to a full buffer");

endmodule : isl_buf2
`default_nettype wire

// ---- hw/isl_latch8.sv ----
`timescale 1ns/1ps
`default_nettype none
module isl_latch8 (
  input wire logic core_clk_i, // core clock, 100 MHz
  input wire logic rst_b_i, // async power-up reset, active low
  input wire logic output_disable_n_i, // async disable, active low
  input wire logic sclk_i, // serial clock pin
  input wire logic cs_n_i, // chip select pin, active low
  input wire logic si_i, // serial data in pin
  output logic so_o, // serial data out value
  output logic so_oe_o, // serial out enable, high drives
  input wire logic [7:0] peak_over_i, // per channel peak current flag
  input wire logic [7:0] temp_over_i, // per channel over temperature
  output logic [7:0] channel_switch_outputs_o // channel gate drive
);
  isl_pkg::isl_spi_t s1_ff;
  isl_pkg::isl_spi_t s2_ff;
  logic sclk_d_ff;
  logic cs_d_ff;
  logic [7:0] shift_ff;
  logic [isl_pkg::CNT_W-1:0] cnt_ff;
  logic [7:0] outbuf_ff;
  logic [2:0] fail_ff;
  logic fail_off_ff;
  logic live_ff;
  isl_pkg::isl_state_t state_ff;
  logic so_ff;
  logic so_oe_ff;
  logic [7:0] chan_ff;
  logic [7:0] pk1_ff;
  logic [7:0] pk2_ff;
  logic [7:0] tp1_ff;
  logic [7:0] tp2_ff;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  logic sel;
  logic rst_all_b;
  logic buf_out_valid;
  isl_pkg::isl_frame_t buf_in;
  isl_pkg::isl_frame_t buf_out;
  logic [7:0] gate;

  // disable acts like reset on the whole front end, no clock needed
  assign rst_all_b = rst_b_i & output_disable_n_i;

  // two flops on every pin before any logic looks at them
  always_ff @(posedge core_clk_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      s1_ff <= '{sclk: 1'b1, cs_n: 1'b1, si: 1'b0};
      s2_ff <= '{sclk: 1'b1, cs_n: 1'b1, si: 1'b0};
    end else begin
      s1_ff <= '{sclk: sclk_i, cs_n: cs_n_i, si: si_i};
      s2_ff <= s1_ff;
    end
  end

  // edge history on the synchronised pins
  always_ff @(posedge core_clk_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      sclk_d_ff <= 1'b1;
      cs_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= s2_ff.sclk;
      cs_d_ff <= s2_ff.cs_n;
    end
  end

  assign sel = !s2_ff.cs_n;
  assign rise = sel && s2_ff.sclk && !sclk_d_ff;
  assign fall = sel && !s2_ff.sclk && sclk_d_ff;
  assign cs_fall = cs_d_ff && !s2_ff.cs_n;
  assign cs_rise = !cs_d_ff && s2_ff.cs_n;

  // selection state
  always_ff @(posedge core_clk_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      state_ff <= isl_pkg::ST_IDLE;
    end else begin
      unique case (state_ff)
        isl_pkg::ST_IDLE: begin
          if (cs_fall) begin
            state_ff <= isl_pkg::ST_SEL;
          end
        end
        isl_pkg::ST_SEL: begin
          if (cs_rise) begin
            state_ff <= isl_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // shift in on rising clock, msb first; clock kept high at cs edges
  // by the master, so no stray edge lands here
  always_ff @(posedge core_clk_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      shift_ff <= isl_pkg::OUT_RESET;
    end else if (rise) begin
      shift_ff <= {shift_ff[6:0], s2_ff.si};
    end
  end

  // modulo-8 pulse count, restarted at each selection
  always_ff @(posedge core_clk_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      cnt_ff <= '0;
    end else if (cs_fall) begin
      cnt_ff <= '0;
    end else if (rise) begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end

  // so: msb shown on select, next bit after each falling edge
  always_ff @(posedge core_clk_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else begin
      so_oe_ff <= sel;
      if (cs_fall || fall) begin
        so_ff <= shift_ff[7];
      end
    end
  end
  assign so_o = so_ff;
  assign so_oe_o = so_oe_ff;

  // hand each finished frame with its verdict to the buffer
  assign buf_in.ok = (cnt_ff == 3'h0);
  assign buf_in.data = shift_ff;

  // the stage takes each frame the cycle after it lands here (out_ready_i tied high), so no frame waits
  isl_buf2 u_buf (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_all_b),
    .in_valid_i(cs_rise && (state_ff == isl_pkg::ST_SEL)),
    .in_ready_o(),
    .in_data_i(buf_in),
    .out_valid_o(buf_out_valid),
    .out_ready_i(1'b1),
    .out_data_o(buf_out)
  );

  // output buffer, failure counter and the live flag
  always_ff @(posedge core_clk_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      outbuf_ff <= isl_pkg::OUT_RESET;
      fail_ff <= 3'h0;
      fail_off_ff <= 1'b0;
      live_ff <= 1'b0;
    end else if (buf_out_valid) begin
      if (buf_out.ok) begin
        outbuf_ff <= buf_out.data;
        fail_ff <= 3'h0;
        fail_off_ff <= 1'b0;
        live_ff <= 1'b1;
      end else if (fail_ff == isl_pkg::FAIL_LIMIT - 3'h1) begin
        fail_off_ff <= 1'b1;
      end else begin
        fail_ff <= fail_ff + 3'h1;
      end
    end
  end

  // pin flags from the power side, synchronised
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pk1_ff <= 8'h00;
      pk2_ff <= 8'h00;
      tp1_ff <= 8'h00;
      tp2_ff <= 8'h00;
    end else begin
      pk1_ff <= peak_over_i;
      pk2_ff <= pk1_ff;
      tp1_ff <= temp_over_i;
      tp2_ff <= tp1_ff;
    end
  end

  // per channel protection: each channel throttles only itself
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ch
      logic [7:0] tcnt_ff;
      logic ton_ff;
      logic [3:0] icnt_ff;
      logic ion_ff;
      // thermal pwm keeps running until the channel cools
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          tcnt_ff <= 8'h00;
          ton_ff <= 1'b0;
        end else if (!tp2_ff[g]) begin
          tcnt_ff <= 8'h00;
          ton_ff <= 1'b0;
        end else if (tcnt_ff == 8'h00) begin
          ton_ff <= !ton_ff;
          tcnt_ff <= ton_ff ? isl_pkg::THERM_OFF_CYC : isl_pkg::THERM_ON_CYC;
        end else begin
          tcnt_ff <= tcnt_ff - 8'h01;
        end
      end
      // repetitive current limit switching
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          icnt_ff <= 4'h0;
          ion_ff <= 1'b0;
        end else if (!pk2_ff[g]) begin
          icnt_ff <= 4'h0;
          ion_ff <= 1'b0;
        end else if (icnt_ff == 4'h0) begin
          ion_ff <= !ion_ff;
          icnt_ff <= ion_ff ? isl_pkg::ILIM_OFF_CYC : isl_pkg::ILIM_ON_CYC;
        end else begin
          icnt_ff <= icnt_ff - 4'h1;
        end
      end
      assign gate[g] = outbuf_ff[g]
        && (!tp2_ff[g] || ton_ff) && (!pk2_ff[g] || ion_ff);
    end
  endgenerate

  // final drive; disable forces off without waiting for a clock
  always_ff @(posedge core_clk_i or negedge rst_all_b) begin
    if (!rst_all_b) begin
      chan_ff <= 8'h00;
    end else begin
      chan_ff <= (live_ff && !fail_off_ff) ? gate : 8'h00;
    end
  end
  assign channel_switch_outputs_o = chan_ff;

  property p_so_float;
    @(posedge core_clk_i) disable iff (!rst_all_b)
      s2_ff.cs_n |=> !so_oe_o;
  endproperty
  a_so_float: assert property (p_so_float)
    else $error("so driven while deselected");

  property p_so_drive;
    @(posedge core_clk_i) disable iff (!rst_all_b)
      sel |=> so_oe_o;
  endproperty
  a_so_drive: assert property (p_so_drive)
    else $error("so not driven while selected");

  property p_shift_in;
    @(posedge core_clk_i) disable iff (!rst_all_b)
      rise |=> shift_ff == {$past(shift_ff[6:0]), $past(s2_ff.si)};
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("shift register missed a bit");

  property p_so_next;
    @(posedge core_clk_i) disable iff (!rst_all_b)
      fall |=> so_o == $past(shift_ff[7]);
  endproperty
  a_so_next: assert property (p_so_next)
    else $error("so not updated after falling edge");

  property p_so_first;
    @(posedge core_clk_i) disable iff (!rst_all_b)
      cs_fall |=> so_o == $past(shift_ff[7]);
  endproperty
  a_so_first: assert property (p_so_first)
    else $error("first so bit is not the msb");

  property p_cnt_restart;
    @(posedge core_clk_i) disable iff (!rst_all_b)
      cs_fall |=> cnt_ff == 3'h0;
  endproperty
  a_cnt_restart: assert property (p_cnt_restart)
    else $error("pulse count not restarted");

  sequence s_bad_frame;
    buf_out_valid && !buf_out.ok;
  endsequence
  property p_keep_on_bad;
    @(posedge core_clk_i) disable iff (!rst_all_b)
      s_bad_frame |=> $stable(outbuf_ff);
  endproperty
  a_keep_on_bad: assert property (p_keep_on_bad)
    else $error("outputs changed on a bad frame");

  property p_load_good;
    @(posedge core_clk_i) disable iff (!rst_all_b)
      buf_out_valid && buf_out.ok |=> outbuf_ff == $past(buf_out.data);
  endproperty
  a_load_good: assert property (p_load_good)
    else $error("good frame not loaded");

  property p_fail_off;
    @(posedge core_clk_i) disable iff (!rst_all_b)
      fail_off_ff |=> channel_switch_outputs_o == 8'h00;
  endproperty
  a_fail_off: assert property (p_fail_off)
    else $error("channels on after link failure");

  property p_wait_frame;
    @(posedge core_clk_i) disable iff (!rst_all_b)
      !live_ff |=> channel_switch_outputs_o == 8'h00;
  endproperty
  a_wait_frame: assert property (p_wait_frame)
    else $error("channels on before a valid frame");

endmodule : isl_latch8
`default_nettype wire

// ---- tb/isl_master.sv ----
`timescale 1ns/1ps
`default_nettype none
// spi master model, sclk half period of 8 core cycles gives 80 ns
module isl_master (
  input wire logic core_clk_i, // core clock
  input wire logic req_i, // start a frame
  input wire logic noise_i, // wiggle sclk while deselected
  input wire logic [4:0] nbits_i, // bits in the frame
  input wire logic [15:0] data_i, // frame, right aligned
  input wire logic so_i, // resolved serial out line
  output logic sclk_o, // serial clock
  output logic cs_n_o, // chip select, active low
  output logic si_o, // serial data
  output logic busy_o, // frame in progress
  output logic [15:0] rx_o // bits seen on so, first in high
);
  int i;
  task automatic half();
    repeat (8) @(negedge core_clk_i);
  endtask : half
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    busy_o = 1'b0;
    rx_o = 16'h0000;
    forever begin
      @(negedge core_clk_i);
      if (!req_i) begin
        // idle si never holds a stale bit, so a listener sees junk
        si_o = ~si_o;
        if (noise_i) begin
          sclk_o = ~sclk_o;
        end
      end else begin
        busy_o = 1'b1;
        sclk_o = 1'b1;
        half();
        cs_n_o = 1'b0;
        rx_o = 16'h0000;
        for (i = 0; i < nbits_i; i++) begin
          half();
          sclk_o = 1'b0;
          si_o = data_i[nbits_i - 1 - i];
          half();
          sclk_o = 1'b1;
          rx_o = {rx_o[14:0], so_i};
        end
        half();
        cs_n_o = 1'b1;
        half();
        busy_o = 1'b0;
      end
    end
  end
endmodule : isl_master
`default_nettype wire

// ---- tb/isl_latch8_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module isl_latch8_bench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic off_n = 1'b1;
  logic req = 1'b0;
  logic noise = 1'b0;
  logic [4:0] nbits = 5'h00;
  logic [15:0] tx = 16'h0000;
  logic [7:0] peak_over = 8'h00;
  logic [7:0] temp_over = 8'h00;
  logic sclk, cs_n, si, so, so_oe, busy;
  logic [15:0] rx;
  logic [7:0] chan;
  wire so_line;
  int err_total = 0;
  int comparisons = 0;
  // the tristate pin as the master sees it
  assign so_line = so_oe ? so : 1'bz;
  always #5 core_clk = ~core_clk;
  isl_latch8 dut (.core_clk_i(core_clk), .rst_b_i(rst_b),
    .output_disable_n_i(off_n), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .peak_over_i(peak_over),
    .temp_over_i(temp_over), .channel_switch_outputs_o(chan));
  isl_master mst (.core_clk_i(core_clk), .req_i(req), .noise_i(noise),
    .nbits_i(nbits), .data_i(tx), .so_i(so_line), .sclk_o(sclk),
    .cs_n_o(cs_n), .si_o(si), .busy_o(busy), .rx_o(rx));
  task automatic results();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_up(input string what);
    err_total++;
    $display("mismatch %s expected done seen timeout", what);
    results();
  endtask : give_up
  // master samples req on negedge, so drive it by nba and watch busy on posedge
  task automatic xfer(input logic [4:0] nb, input logic [15:0] d);
    int k;
    @(negedge core_clk);
    nbits <= nb;
    tx <= d;
    req <= 1'b1;
    for (k = 0; k < 20 && busy !== 1'b1; k++) @(posedge core_clk);
    if (busy !== 1'b1) give_up("frame start");
    @(negedge core_clk);
    req <= 1'b0;
    for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge core_clk);
    if (busy !== 1'b0) give_up("frame end");
  endtask : xfer
  task automatic wait_chan(input logic [7:0] exp);
    int k;
    for (k = 0; k < 40 && chan !== exp; k++) @(negedge core_clk);
    chk("channels", {8'h00, exp}, {8'h00, chan});
  endtask : wait_chan
  task automatic hold_chan(input logic [7:0] exp);
    repeat (30) @(negedge core_clk);
    chk("channels held", {8'h00, exp}, {8'h00, chan});
  endtask : hold_chan
  // channel ch must both switch on and off, all others stay on
  task automatic watch(input int ch, input int n);
    int k;
    int on_n = 0;
    int off_n = 0;
    logic [7:0] rest = 8'h00;
    for (k = 0; k < n; k++) begin
      @(negedge core_clk);
      if (chan[ch] === 1'b1) on_n++;
      else off_n++;
      rest = rest | ((chan ^ 8'hff) & ~(8'h01 << ch));
    end
    chk("seen on", 16'h0001, {15'h0000, on_n > 0});
    chk("seen off", 16'h0001, {15'h0000, off_n > 0});
    chk("other channels", 16'h0000, {8'h00, rest});
  endtask : watch
  task automatic t_reset();
    chk("reset channels", 16'h0000, {8'h00, chan});
    chk("idle so", {15'h0000, 1'bz}, {15'h0000, so_line});
  endtask : t_reset
  task automatic t_basic();
    xfer(5'h08, 16'h00a5);
    wait_chan(8'ha5);
    chk("so bits", 16'h0000, rx);
    xfer(5'h08, 16'h003c);
    wait_chan(8'h3c);
    chk("so bits", 16'h00a5, rx);
  endtask : t_basic
  task automatic t_bad();
    xfer(5'h07, 16'h007f);
    hold_chan(8'h3c);
    xfer(5'h09, 16'h01ff);
    hold_chan(8'h3c);
    xfer(5'h10, 16'h12c3);
    wait_chan(8'hc3);
    chk("chain bits", 16'hff12, rx);
  endtask : t_bad
  task automatic t_noise();
    noise <= 1'b1;
    repeat (60) @(negedge core_clk);
    chk("idle so", {15'h0000, 1'bz}, {15'h0000, so_line});
    noise <= 1'b0;
    hold_chan(8'hc3);
    xfer(5'h08, 16'h005a);
    wait_chan(8'h5a);
  endtask : t_noise
  task automatic t_fail();
    int k;
    xfer(5'h08, 16'h00ff);
    wait_chan(8'hff);
    for (k = 0; k < 3; k++) xfer(5'h05, 16'h0000);
    hold_chan(8'hff);
    xfer(5'h05, 16'h0000);
    wait_chan(8'h00);
    xfer(5'h08, 16'h0081);
    wait_chan(8'h81);
  endtask : t_fail
  task automatic t_disable();
    off_n <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk("disabled", 16'h0000, {8'h00, chan});
    off_n <= 1'b1;
    hold_chan(8'h00);
    xfer(5'h08, 16'h0066);
    wait_chan(8'h66);
    chk("cleared shift", 16'h0000, rx);
  endtask : t_disable
  task automatic t_prot();
    xfer(5'h08, 16'h00ff);
    wait_chan(8'hff);
    peak_over <= 8'h04;
    repeat (10) @(negedge core_clk);
    watch(2, 40);
    peak_over <= 8'h00;
    wait_chan(8'hff);
    temp_over <= 8'h20;
    repeat (10) @(negedge core_clk);
    watch(5, 600);
    temp_over <= 8'h00;
    wait_chan(8'hff);
  endtask : t_prot
  initial begin
    repeat (5) @(negedge core_clk);
    rst_b <= 1'b1;
    repeat (5) @(negedge core_clk);
    t_reset();
    t_basic();
    t_bad();
    t_noise();
    t_fail();
    t_disable();
    t_prot();
    results();
  end
endmodule : isl_latch8_bench
`default_nettype wire
